// ===== src/fssr_core.sv
`default_nettype none
// Summary of operation
// - Scan compares disk and host bytes for equal, low-or-equal, high-or-equal.
// - An FF byte on either side always satisfies the comparison.
// - Bytes compare as unsigned values, FF largest, 00 smallest.
// - An unmet sector adds the increment to the sector number and continues.
// - Scan runs until hit, final sector done, or terminal count.
// - A hit sets the scan hit flag in status 2 bit 3 and ends.
// - No hit through the final sector sets status 2 bit 2 and ends.
// - Terminal count ends the scan after the byte in progress completes.
// - Without skip, a deleted sector ends the scan with the deleted mark flag.
// - With skip, a deleted sector is passed over and the flag is set.
// - Overrun ends the command with status 0 bits 7,6 equal to 0,1.
// - Four present cylinder registers, cleared only by reset and by recalibrate.
// - Below target steps inward with direction high; above, outward, low.
// - Step spacing follows the step interval setting.
// - After each step compare; on equal set positioning done and interrupt.
// - Per-drive seeking bits set during seek, cleared by sense interrupt.
// - Busy only in command phase; host issues nothing else while stepping.
// - Recalibrate clears cylinder, steps out while track zero low, ends high.
// - After 77 steps without track zero set drive fault, abnormal end.
// - Recalibrates, like seeks, do not overlap: one drive positions at a time.
// - Setting selects 1 to 16 ms, higher code gives shorter interval.
// - Sense interrupt clears interrupt; status 0 bits 5-7 report cause.
module fssr_core (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCAN_START,
  input wire logic [1:0] SCAN_MODE,
  input wire logic PASS_OVER_DELETED,
  input wire logic MFM_MODE,
  input wire logic [7:0] START_SECTOR,
  input wire logic [7:0] FINAL_SECTOR_NUMBER,
  input wire logic [7:0] SECTOR_INCREMENT,
  input wire logic DISK_VALID,
  input wire logic [7:0] DISK_BYTE,
  input wire logic DISK_LAST,
  input wire logic DISK_DELETED,
  input wire logic HOST_VALID,
  input wire logic [7:0] HOST_BYTE,
  input wire logic TC_PIN,
  input wire logic SEEK_START,
  input wire logic RECAL_START,
  input wire logic [1:0] DRIVE_SEL,
  input wire logic [7:0] TARGET_CYLINDER,
  input wire logic [3:0] STEP_INTERVAL_SETTING,
  input wire logic SENSE_INT,
  input wire logic TRACK0_PIN,
  output logic HOST_TAKEN,
  output logic SCAN_BUSY,
  output logic SCAN_DONE,
  output logic [7:0] SECTOR_NUMBER,
  output logic [7:0] ST0,
  output logic [7:0] ST1,
  output logic [7:0] ST2,
  output logic [3:0] DRIVE_SEEKING_BITS,
  output logic STEPPING,
  output logic STEP,
  output logic DIRECTION,
  output logic [1:0] STEP_DRIVE,
  output logic INT_OUT,
  output logic [7:0] PRESENT_CYLINDER
);
  typedef enum logic [1:0]
  {
    SC_IDLE = 2'b00,
    SC_RUN = 2'b01,
    SC_END = 2'b10
  } fssr_scan_type;
  typedef enum logic [1:0]
  {
    PS_IDLE = 2'b00,
    PS_WAIT = 2'b01,
    PS_PULSE = 2'b10,
    PS_CHECK = 2'b11
  } fssr_pos_type;
  typedef struct packed
  {
    fssr_scan_type scan;
    logic [7:0] sector;
    logic sect_fail;
    logic tc_seen;
    logic [13:0] ovr_cnt;
    logic host_taken;
    logic scan_done;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    fssr_pos_type pos;
    logic recal;
    logic [1:0] drv;
    logic [31:0] wait_cnt;
    logic [6:0] steps;
    logic [3:0][7:0] present_cylinder;
    logic [3:0] seeking;
    logic step;
    logic dir;
    logic irq;
    logic [7:0] pcn_out;
    logic busy;
    logic stepping;
  } fssr_core_type;
  fssr_core_type q, d;
  logic tc_s;
  logic trk0_s;
  logic byte_ok;
  logic [31:0] step_cyc;
  logic [13:0] ovr_lim;
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // synchronise pin inputs
  fssr_sync u_sync_tc (.clk(SYS_CLK), .rst(RST), .din(TC_PIN), .dout(tc_s));
  fssr_sync u_sync_t0 (.clk(SYS_CLK), .rst(RST), .din(TRACK0_PIN), .dout(trk0_s));
  // ------------------------------------------------------------
  // Comparison and timing terms
  // ------------------------------------------------------------
  always_comb
  begin
    if (DISK_BYTE == fssr_pkg::MASK_BYTE || HOST_BYTE == fssr_pkg::MASK_BYTE)
    begin
      byte_ok = 1'b1;
    end
    else
    begin
      case (SCAN_MODE)
        fssr_pkg::SCAN_LE: byte_ok = DISK_BYTE <= HOST_BYTE;
        fssr_pkg::SCAN_GE: byte_ok = DISK_BYTE >= HOST_BYTE;
        default: byte_ok = DISK_BYTE == HOST_BYTE;
      endcase
    end
    step_cyc = (32'd16 - {28'h0, STEP_INTERVAL_SETTING}) * fssr_pkg::STEP_UNIT_CYC;
    ovr_lim = MFM_MODE ? 14'(fssr_pkg::OVR_MFM_CYC) : 14'(fssr_pkg::OVR_FM_CYC);
  end
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.host_taken = 1'b0;
    d.scan_done = 1'b0;
    d.step = 1'b0;
    case (q.scan)
      SC_IDLE:
      begin
        if (SCAN_START)
        begin
          d.scan = SC_RUN;
          d.sector = START_SECTOR;
          d.sect_fail = 1'b0;
          d.tc_seen = 1'b0;
          d.ovr_cnt = '0;
          d.st0 = '0;
          d.st1 = '0;
          d.st2 = '0;
        end
      end
      SC_RUN:
      begin
        if (tc_s)
        begin
          d.tc_seen = 1'b1;
        end
        if (DISK_VALID)
        begin
          d.ovr_cnt = q.ovr_cnt + 14'h1;
          if (q.ovr_cnt >= ovr_lim)
          begin
            d.st1[fssr_pkg::ST1_OVERRUN] = 1'b1;
            d.st0[fssr_pkg::ST0_IC_LO] = 1'b1;
            d.scan = SC_END;
          end
          else if (HOST_VALID)
          begin
            d.host_taken = 1'b1;
            d.ovr_cnt = '0;
            if (DISK_DELETED)
            begin
              d.st2[fssr_pkg::ST2_DELETED] = 1'b1;
            end
            if (!byte_ok)
            begin
              d.sect_fail = 1'b1;
            end
            // finish byte then end on tc
            if (tc_s || q.tc_seen)
            begin
              d.scan = SC_END;
            end
            else if (DISK_LAST)
            begin
              d.sect_fail = 1'b0;
              if (DISK_DELETED)
              begin
                if (!PASS_OVER_DELETED || q.sector == FINAL_SECTOR_NUMBER)
                begin
                  d.scan = SC_END;
                end
                else
                begin
                  d.sector = q.sector + SECTOR_INCREMENT;
                end
              end
              else if (!q.sect_fail && byte_ok)
              begin
                d.st2[fssr_pkg::ST2_SCAN_HIT] = 1'b1;
                d.scan = SC_END;
              end
              else if (q.sector >= FINAL_SECTOR_NUMBER)
              begin
                d.st2[fssr_pkg::ST2_SCAN_UNMET] = 1'b1;
                d.scan = SC_END;
              end
              else
              begin
                d.sector = q.sector + SECTOR_INCREMENT;
              end
            end
          end
        end
        // terminal count with no byte pending
        else if (tc_s || q.tc_seen)
        begin
          d.scan = SC_END;
        end
      end
      SC_END:
      begin
        d.scan_done = 1'b1;
        d.scan = SC_IDLE;
      end
      default:
      begin
        d.scan = SC_IDLE;
      end
    endcase
    if (SENSE_INT)
    begin
      d.irq = 1'b0;
      d.seeking = '0;
    end
    case (q.pos)
      PS_IDLE:
      begin
        if (SEEK_START || RECAL_START)
        begin
          d.drv = DRIVE_SEL;
          d.recal = RECAL_START;
          d.steps = '0;
          d.wait_cnt = '0;
          d.seeking[DRIVE_SEL] = 1'b1;
          d.st0 = {6'h0, DRIVE_SEL};
          if (RECAL_START)
          begin
            d.present_cylinder[DRIVE_SEL] = '0;
          end
          d.pos = PS_CHECK;
        end
      end
      PS_CHECK:
      begin
        if (q.recal ? trk0_s : q.present_cylinder[q.drv] == TARGET_CYLINDER)
        begin
          d.st0[fssr_pkg::ST0_SEEK_END] = 1'b1;
          d.irq = 1'b1;
          d.pos = PS_IDLE;
        end
        else if (q.recal && q.steps == fssr_pkg::RECAL_STEPS)
        begin
          d.st0[fssr_pkg::ST0_SEEK_END] = 1'b1;
          d.st0[fssr_pkg::ST0_DRIVE_FAULT] = 1'b1;
          d.st0[fssr_pkg::ST0_IC_LO] = 1'b1;
          d.irq = 1'b1;
          d.pos = PS_IDLE;
        end
        else
        begin
          d.dir = !q.recal && q.present_cylinder[q.drv] < TARGET_CYLINDER;
          d.pos = PS_WAIT;
        end
      end
      PS_WAIT:
      begin
        d.wait_cnt = q.wait_cnt + 32'h1;
        if (q.wait_cnt + 32'h1 >= step_cyc)
        begin
          d.wait_cnt = '0;
          d.pos = PS_PULSE;
        end
      end
      PS_PULSE:
      begin
        d.step = 1'b1;
        d.wait_cnt = q.wait_cnt + 32'h1;
        if (q.wait_cnt == 32'(fssr_pkg::STEP_PULSE_CYC - 1))
        begin
          d.wait_cnt = '0;
          d.steps = q.steps + 7'h1;
          if (!q.recal)
          begin
            d.present_cylinder[q.drv] = q.dir ? q.present_cylinder[q.drv] + 8'h1 : q.present_cylinder[q.drv] - 8'h1;
          end
          d.pos = PS_CHECK;
        end
      end
      default:
      begin
        d.pos = PS_IDLE;
      end
    endcase
    d.pcn_out = d.present_cylinder[DRIVE_SEL];
    d.busy = d.scan != SC_IDLE;
    d.stepping = d.pos != PS_IDLE;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign HOST_TAKEN = q.host_taken;
  assign SCAN_BUSY = q.busy;
  assign SCAN_DONE = q.scan_done;
  assign SECTOR_NUMBER = q.sector;
  assign ST0 = q.st0;
  assign ST1 = q.st1;
  assign ST2 = q.st2;
  assign DRIVE_SEEKING_BITS = q.seeking;
  assign STEPPING = q.stepping;
  assign STEP = q.step;
  assign DIRECTION = q.dir;
  assign STEP_DRIVE = q.drv;
  assign INT_OUT = q.irq;
  assign PRESENT_CYLINDER = q.pcn_out;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_hit_byte;
    q.scan == SC_RUN && DISK_VALID && HOST_VALID && DISK_LAST && !DISK_DELETED
      && !q.sect_fail && byte_ok && !tc_s && !q.tc_seen && q.ovr_cnt < ovr_lim;
  endsequence
  property p_scan_hit;
    @(posedge SYS_CLK) disable iff (RST) s_hit_byte |=> q.st2[3] ##1 q.scan_done;
  endproperty
  a_scan_hit: assert property (p_scan_hit) else $error("scan hit not flagged");
  property p_mask;
    @(posedge SYS_CLK) disable iff (RST) (DISK_BYTE == 8'hFF) |-> byte_ok;
  endproperty
  a_mask: assert property (p_mask) else $error("mask byte failed compare");
  property p_dir_in;
    @(posedge SYS_CLK) disable iff (RST)
      (q.pos == PS_CHECK && !q.recal && q.present_cylinder[q.drv] < TARGET_CYLINDER) |=> q.dir;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("step in direction wrong");
  property p_recal_dir;
    @(posedge SYS_CLK) disable iff (RST) (q.step && q.recal) |-> !q.dir;
  endproperty
  a_recal_dir: assert property (p_recal_dir) else $error("recalibrate steps inward");
  property p_recal_limit;
    @(posedge SYS_CLK) disable iff (RST) q.recal |-> q.steps <= 7'd77;
  endproperty
  a_recal_limit: assert property (p_recal_limit) else $error("too many recal steps");
  property p_seek_end_irq;
    @(posedge SYS_CLK) disable iff (RST)
      (q.pos == PS_CHECK && !q.recal && q.present_cylinder[q.drv] == TARGET_CYLINDER && !SENSE_INT)
      |=> q.irq && q.st0[5];
  endproperty
  a_seek_end_irq: assert property (p_seek_end_irq) else $error("seek end missing");
  property p_sense;
    @(posedge SYS_CLK) disable iff (RST) SENSE_INT |=> !q.irq || $past(q.pos) == PS_CHECK;
  endproperty
  a_sense: assert property (p_sense) else $error("interrupt not cleared");
  property p_pulse_len;
    @(posedge SYS_CLK) disable iff (RST) $rose(q.step) |-> q.step [*8] ##1 !q.step;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("step pulse length");
endmodule
`default_nettype wire

// ===== src/fssr_pkg.sv
`default_nettype none
package fssr_pkg;
  // Scan conditions.
  localparam logic [1:0] SCAN_EQ = 2'h0;
  localparam logic [1:0] SCAN_LE = 2'h1;
  localparam logic [1:0] SCAN_GE = 2'h2;
  localparam logic [7:0] MASK_BYTE = 8'hFF;
  // Status register bit positions.
  localparam int ST0_IC_HI = 7;
  localparam int ST0_IC_LO = 6;
  localparam int ST0_SEEK_END = 5;
  localparam int ST0_DRIVE_FAULT = 4;
  localparam int ST1_OVERRUN = 4;
  localparam int ST2_DELETED = 6;
  localparam int ST2_SCAN_HIT = 3;
  localparam int ST2_SCAN_UNMET = 2;
  // Recalibrate step limit.
  localparam logic [6:0] RECAL_STEPS = 7'h4D;
  // Step timing counts clock cycles: one unit is 1 ms at a 16 MHz reference clock.
  // A faster or slower clock scales every interval by the same factor.
  localparam int CLK_MHZ = 125;
  localparam int STEP_REF_MHZ = 16;
  localparam int STEP_UNIT_US = 1000;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * STEP_REF_MHZ;
  localparam int STEP_PULSE_CYC = 8;
  // Overrun timeouts.
  localparam int OVR_FM_US = 27;
  localparam int OVR_MFM_US = 13;
  localparam int OVR_FM_CYC = OVR_FM_US * CLK_MHZ;
  localparam int OVR_MFM_CYC = OVR_MFM_US * CLK_MHZ;
endpackage
`default_nettype wire

// ===== src/fssr_sync.sv
`default_nettype none
module fssr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  typedef struct packed
  {
    logic s1;
    logic s2;
  } fssr_sync_type;
  fssr_sync_type q, d;
  always_comb
  begin
    d.s1 = din;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
  assign dout = q.s2;
endmodule
`default_nettype wire

// ===== tb/fssr_drive_model.sv
`default_nettype none
module fssr_drive_model (
  input wire logic step,
  input wire logic direction,
  input wire logic [1:0] step_drive,
  input wire logic [1:0] drive_sel,
  output logic track0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] head_pos [4];
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      head_pos[i] = 8'h00;
    end
  end
  // ----------------------------------------
  // Head motion of each drive
  // ----------------------------------------
  // direction sets motion
  always @(posedge step)
  begin
    if (direction)
    begin
      head_pos[step_drive] <= head_pos[step_drive] + 8'h01;
    end
    else if (head_pos[step_drive] != 8'h00)
    begin
      head_pos[step_drive] <= head_pos[step_drive] - 8'h01;
    end
  end
  assign track0 = (head_pos[drive_sel] == 8'h00);
endmodule
`default_nettype wire

// ===== tb/floppy_scan_seek_recal_test.sv
`default_nettype none
module floppy_scan_seek_recal_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, scan_go, skip, mfm, d_valid, d_last, d_del, h_valid, tc;
  logic seek_go, recal_go, sense, trk0, h_taken, busy, done, stepping, step, dir, int_out;
  logic [1:0] mode, drv_sel, step_drv;
  logic [3:0] rate, seeking;
  logic [7:0] st_sec, fin_sec, inc, d_byte, h_byte, tgt, sec_no, st0, st1, st2, cyl;
  int error_cnt, n_compared, n;
  fssr_core fssr_core_inst (.SYS_CLK(sys_clk), .RST(rst), .SCAN_START(scan_go),
    .SCAN_MODE(mode), .PASS_OVER_DELETED(skip), .MFM_MODE(mfm), .START_SECTOR(st_sec),
    .FINAL_SECTOR_NUMBER(fin_sec), .SECTOR_INCREMENT(inc), .DISK_VALID(d_valid),
    .DISK_BYTE(d_byte), .DISK_LAST(d_last), .DISK_DELETED(d_del), .HOST_VALID(h_valid),
    .HOST_BYTE(h_byte), .TC_PIN(tc), .SEEK_START(seek_go), .RECAL_START(recal_go),
    .DRIVE_SEL(drv_sel), .TARGET_CYLINDER(tgt), .STEP_INTERVAL_SETTING(rate),
    .SENSE_INT(sense), .TRACK0_PIN(trk0), .HOST_TAKEN(h_taken), .SCAN_BUSY(busy),
    .SCAN_DONE(done), .SECTOR_NUMBER(sec_no), .ST0(st0), .ST1(st1), .ST2(st2),
    .DRIVE_SEEKING_BITS(seeking), .STEPPING(stepping), .STEP(step), .DIRECTION(dir),
    .STEP_DRIVE(step_drv), .INT_OUT(int_out), .PRESENT_CYLINDER(cyl));
  fssr_drive_model fssr_drive_model_inst (.step(step), .direction(dir),
    .step_drive(step_drv), .drive_sel(drv_sel), .track0(trk0));
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask
  task automatic start_scan(input logic [1:0] md, input logic sk, input logic [7:0] s,
    input logic [7:0] f, input logic [7:0] i);
    @(negedge sys_clk);
    mode = md;
    skip = sk;
    st_sec = s;
    fin_sec = f;
    inc = i;
    scan_go = 1'h1;
    @(negedge sys_clk);
    scan_go = 1'h0;
  endtask
  // The host byte is offered with the disk byte, well inside the overrun limit.
  task automatic pair(input logic [7:0] d, input logic [7:0] h, input logic l,
    input logic dl);
    int k;
    k = 0;
    d_valid = 1'h1;
    h_valid = 1'h1;
    d_byte = d;
    h_byte = h;
    d_last = l;
    d_del = dl;
    do
    begin
      @(negedge sys_clk);
      k++;
    end
    while (h_taken !== 1'h1 && k < 50);
    chk("pair taken", 8'h01, {7'h00, h_taken});
    d_valid = 1'h0;
    h_valid = 1'h0;
    d_last = 1'h0;
    @(negedge sys_clk);
  endtask
  task automatic sector(input logic [7:0] d0, input logic [7:0] h0, input logic [7:0] d1,
    input logic [7:0] h1, input logic dl);
    pair(d0, h0, 1'h0, dl);
    pair(d1, h1, 1'h1, dl);
  endtask
  task automatic finish(input string nm, input logic [7:0] msk, input logic [7:0] ex,
    input logic [7:0] sec, input int lim);
    n = 0;
    while (done !== 1'h1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({nm, " done"}, 8'h01, {7'h00, done});
    chk({nm, " busy"}, 8'h00, {7'h00, busy});
    chk({nm, " st2"}, ex, st2 & msk);
    chk({nm, " sector"}, sec, sec_no);
    $display("test %s finished", nm);
  endtask
  task automatic command(input logic rc, input logic [1:0] d, input logic [7:0] t);
    @(negedge sys_clk);
    drv_sel = d;
    tgt = t;
    seek_go = ~rc;
    recal_go = rc;
    @(negedge sys_clk);
    seek_go = 1'h0;
    recal_go = 1'h0;
  endtask
  // Each positioning interrupt is followed by a sense before the next command.
  task automatic wait_int(input string nm, input int lim, input logic [7:0] ex0,
    input int d);
    n = 0;
    while (int_out !== 1'h1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({nm, " st0"}, ex0, st0);
    chk({nm, " seeking"}, 8'h01, {7'h00, seeking[d]});
    sense = 1'h1;
    @(negedge sys_clk);
    sense = 1'h0;
    @(negedge sys_clk);
    chk({nm, " sensed"}, 8'h00, {3'h0, int_out, seeking});
    $display("test %s finished", nm);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {rst, scan_go, skip, mfm, d_valid, d_last, d_del, h_valid, tc} = 9'h100;
    {seek_go, recal_go, sense, mode, drv_sel} = 7'h00;
    {st_sec, fin_sec, inc, d_byte, h_byte, tgt} = 48'h0;
    rate = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(negedge sys_clk);
    rst = 1'h0;
    start_scan(fssr_pkg::SCAN_EQ, 1'h0, 8'h01, 8'h05, 8'h01);
    sector(8'h12, 8'hFF, 8'hFF, 8'h34, 1'h0);
    finish("eq_mask", 8'h0C, 8'h08, 8'h01, 50);
    start_scan(fssr_pkg::SCAN_LE, 1'h0, 8'h01, 8'h05, 8'h02);
    sector(8'h80, 8'h7F, 8'h00, 8'h00, 1'h0);
    sector(8'h7F, 8'h80, 8'h05, 8'h05, 1'h0);
    finish("le_step", 8'h0C, 8'h08, 8'h03, 50);
    start_scan(fssr_pkg::SCAN_GE, 1'h0, 8'h04, 8'h04, 8'h01);
    sector(8'h10, 8'h20, 8'h30, 8'h30, 1'h0);
    finish("ge_unmet", 8'h0C, 8'h04, 8'h04, 50);
    start_scan(fssr_pkg::SCAN_EQ, 1'h0, 8'h01, 8'h05, 8'h01);
    sector(8'h10, 8'h20, 8'h10, 8'h20, 1'h1);
    finish("del_stop", 8'h48, 8'h40, 8'h01, 50);
    start_scan(fssr_pkg::SCAN_EQ, 1'h1, 8'h01, 8'h05, 8'h01);
    sector(8'h10, 8'h20, 8'h10, 8'h20, 1'h1);
    sector(8'hAA, 8'hAA, 8'hBB, 8'hBB, 1'h0);
    finish("del_skip", 8'h48, 8'h48, 8'h02, 50);
    start_scan(fssr_pkg::SCAN_EQ, 1'h0, 8'h01, 8'h05, 8'h01);
    pair(8'h10, 8'h20, 1'h0, 1'h0);
    tc = 1'h1;
    finish("tc_end", 8'h0C, 8'h00, 8'h01, 50);
    tc = 1'h0;
    repeat (4) @(negedge sys_clk);
    mfm = 1'h1;
    start_scan(fssr_pkg::SCAN_EQ, 1'h0, 8'h01, 8'h05, 8'h01);
    d_valid = 1'h1;
    finish("overrun", 8'h00, 8'h00, 8'h01, fssr_pkg::OVR_MFM_CYC + 50);
    d_valid = 1'h0;
    chk("overrun late", 8'h01, {7'h00, n >= fssr_pkg::OVR_MFM_CYC - 4});
    chk("overrun st1", 8'h10, st1 & 8'h10);
    chk("overrun st0", 8'h40, st0 & 8'hC0);
    command(1'h0, 2'h1, 8'h00);
    wait_int("seek_equal", 20, 8'h21, 1);
    command(1'h1, 2'h2, 8'h00);
    wait_int("recal_home", 20, 8'h22, 2);
    chk("recal cylinder", 8'h00, cyl);
    command(1'h0, 2'h0, 8'h01);
    n = 0;
    while (step !== 1'h1 && n < fssr_pkg::STEP_UNIT_CYC + 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("step spacing", 8'h01, {7'h00, n >= fssr_pkg::STEP_UNIT_CYC - 4});
    chk("step inward", 8'h03, {6'h00, dir, stepping});
    n = 0;
    while (step === 1'h1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("step width", 8'h08, n[7:0]);
    wait_int("seek_in", 100, 8'h20, 0);
    chk("seek cylinder", 8'h01, cyl);
    drv_sel = 2'h2;
    repeat (2) @(negedge sys_clk);
    chk("other cylinder", 8'h00, cyl);
    test_done();
  end
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    test_done();
  end
endmodule
`default_nettype wire
